// ===== dv/pcrs_core_model.sv
/*
  Model of the decoder and execution core that feeds the block one op a request.
  Assumes the bench raises go for one cycle with cmd and alu_cmd.
*/
`timescale 1ns/1ps
module pcrs_core_model
  import pcrs_pkg::*;
(
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // Bench side
  input  wire logic           go,
  input  wire pcrs_core_req_t cmd,
  input  wire pcrs_alu_t      alu_cmd,
  // Core side
  output pcrs_core_req_t      core_req,
  output pcrs_alu_t           alu
);
  logic [31:0] junk_q;
  // ------------------------------------------------------------
  // Idle fields toggle so stale operands are never trusted
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      junk_q <= 32'h0000_0000;
    end else begin
      junk_q <= ~junk_q;
    end
  end
  always_comb begin
    core_req = go ? cmd : pcrs_core_req_t'({OP_NONE, junk_q[26:0]});
    alu      = go ? alu_cmd : pcrs_alu_t'({3'b000, junk_q[10:0]});
  end
endmodule

// ===== dv/pcrs_core_tb_top.sv
/*
  Self-checking bench for the program counter and return stack.
  Assumes one op taken per edge; APB transfers wait on pready.
*/
`timescale 1ns/1ps
module pcrs_core_tb_top;
  import pcrs_pkg::*;
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, go, err, seen, srq;
  logic           srst, tmo, slp, wdc;
  logic [7:0]     paddr, status_q;
  logic [31:0]    pwdata, prdata, rd, rnd;
  logic [14:0]    pc_q, pc, stk [16];
  logic [6:0]     latch;
  logic [4:0]     sp;
  pcrs_core_req_t cmd, core_req;
  pcrs_alu_t      alu_cmd, alu;
  int             error_cnt, checks, cycles;
  pcrs_op_t       rets [3] = '{OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT};

  pcrs_core i_pcrs_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_req(core_req),
    .alu(alu), .soft_reset(srst), .timeout_evt(tmo), .sleep_evt(slp), .wdt_clear_evt(wdc), .pc_q(pc_q),
    .status_q(status_q), .stack_reset_req_q(srq), .irq(irq));
  pcrs_core_model i_pcrs_core_model (.pclk(pclk), .presetn(presetn), .go(go), .cmd(cmd), .alu_cmd(alu_cmd),
    .core_req(core_req), .alu(alu));

  // ------------------------------------------------------------
  // Clock, timeout, helpers
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Holds the request until pready is seen; data taken at that edge; only the timeout ends a wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic op(input pcrs_op_t o, input logic [10:0] opd, input logic [7:0] w, input pcrs_alu_t a = '0,
                    input logic [7:0] wd = 8'h00);
    @(posedge pclk);
    go      <= 1'b1;
    cmd     <= '{o, opd, w, wd};
    alu_cmd <= a;
    @(posedge pclk);
    go <= 1'b0;
    @(negedge pclk);
  endtask
  // Circular stack model: wraps on overflow and on underflow
  task automatic push(input logic [14:0] v);
    sp = (sp == SP_FULL) ? SP_WRAP : sp + 5'h01;
    stk[sp[3:0]] = v;
  endtask
  task automatic pop;
    pc = stk[sp[3:0]];
    sp = (sp == SP_EMPTY) ? SP_FULL : sp - 5'h01;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, go, paddr, pwdata} = '0;
    {srst, tmo, slp, wdc} = '0;
    cmd = '0;
    alu_cmd = '0;
    {error_cnt, checks, cycles} = '0;
    rnd = 32'h01143015;
    sp = SP_EMPTY;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("pc reset", 32'(PC_RESET), 32'(pc_q));
    apb(1'b0, ADDR_STK_PTR, 32'h0);
    chk("sp reset", 32'(SP_EMPTY), rd);
    rnd = lfsr(rnd);
    latch = rnd[6:0];
    apb(1'b1, ADDR_PC_LATCH, 32'(latch));
    apb(1'b1, ADDR_PC_LOW, 32'(rnd[15:8]));
    pc = {latch, rnd[15:8]};
    chk("pc low write", 32'(pc), 32'(pc_q));
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status write", 32'h18, rd);
    // Write data is the inverse of the result, so a leaked write shows up
    op(OP_NONE, 11'h0, 8'h0, '{1'b1, 1'b1, 1'b1, rnd[0], rnd[1], rnd[2], {5'h00, ~rnd[0], rnd[1], rnd[2]}});
    chk("alu flags", {27'h0, 2'b11, rnd[0], ~rnd[1], ~rnd[2]}, 32'(status_q));
    for (int i = 0; i < 17; i++) begin
      rnd = lfsr(rnd);
      if (i == 5) begin
        push(pc);
        pc = VECTOR_ADDR;
        op(OP_VECTOR, 11'h0, 8'h0);
      end else if (i % 2 == 1) begin
        push(pc + 15'h1);
        pc = {latch, rnd[7:0]};
        op(OP_REGISTER_CALL, 11'h0, rnd[7:0]);
      end else begin
        push(pc + 15'h1);
        pc = {latch[6:3], rnd[18:8]};
        op(OP_CALL, rnd[18:8], 8'h0);
      end
      chk("pc call", 32'(pc), 32'(pc_q));
    end
    apb(1'b0, ADDR_STK_FLAG, 32'h0);
    chk("overflow flag", 32'h1, rd);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b0, ADDR_STK_PTR, 32'h0);
    chk("sp wrap", 32'(sp), rd);
    apb(1'b0, ADDR_TOS_LOW, 32'h0);
    chk("tos low", 32'(stk[0][7:0]), rd);
    apb(1'b0, ADDR_TOS_HIGH, 32'h0);
    chk("tos high", 32'(stk[0][14:8]), rd);
    apb(1'b1, ADDR_IRQ_MASK, 32'h3);
    chk("irq raised", 32'h1, 32'(irq));
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("irq status", 32'h1, rd);
    chk("irq cleared", 32'h0, 32'(irq));
    for (int i = 0; i < 3; i++) begin
      pop();
      op(rets[i], 11'h0, 8'h0);
      chk("pc return", 32'(pc), 32'(pc_q));
    end
    chk("irq underflow", 32'h1, 32'(irq));
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      if (i % 2 == 1) begin
        pc = pc + 15'h1 + {{6{rnd[8]}}, rnd[8:0]};
        op(OP_IMMEDIATE_BRANCH, rnd[10:0], 8'h0);
      end else begin
        rnd[23:16] = (i == 2) ? 8'hFF : rnd[23:16];
        pc = pc + 15'h1 + {7'h0, rnd[23:16]};
        op(OP_REGISTER_BRANCH, 11'h0, rnd[23:16]);
      end
      chk("pc branch", 32'(pc), 32'(pc_q));
    end
    apb(1'b0, ADDR_PC_LATCH, 32'h0);
    chk("latch kept", 32'(latch), rd);
    rnd = lfsr(rnd);
    pc = {latch, rnd[31:24]};
    op(OP_WRITE_PCL, 11'h0, 8'h0, '0, rnd[31:24]);
    chk("pc low op write", 32'(pc), 32'(pc_q));
    pc = pc + 15'h1;
    op(OP_STEP, 11'h0, 8'h0);
    chk("pc step", 32'(pc), 32'(pc_q));
    // Reset-cause flags move only on their events, never on a write
    @(posedge pclk);
    {tmo, slp} <= 2'b11;
    @(posedge pclk);
    {tmo, slp} <= 2'b00;
    apb(1'b1, ADDR_STATUS, 32'h1F);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status events", 32'h07, rd);
    @(posedge pclk);
    wdc <= 1'b1;
    @(posedge pclk);
    wdc <= 1'b0;
    @(negedge pclk);
    chk("reset cause set", 32'h1F, 32'(status_q));
    @(posedge pclk);
    srst <= 1'b1;
    @(posedge pclk);
    srst <= 1'b0;
    @(negedge pclk);
    chk("pc soft reset", 32'(PC_RESET), 32'(pc_q));
    apb(1'b0, ADDR_STK_PTR, 32'h0);
    chk("sp soft reset", 32'(SP_EMPTY), rd);
    apb(1'b0, ADDR_STK_FLAG, 32'h0);
    chk("flags soft reset", 32'h3, rd);
    apb(1'b1, ADDR_STK_FLAG, 32'h3);
    apb(1'b1, ADDR_CONFIG, 32'h1);
    apb(1'b1, ADDR_STK_PTR, 32'(SP_EMPTY));
    op(OP_RETURN, 11'h0, 8'h0);
    seen = 1'b0;
    repeat (3) begin
      seen = seen | (srq === 1'b1);
      @(negedge pclk);
    end
    chk("stack reset", 32'h1, 32'(seen));
    chk("pc fault", 32'(PC_RESET), 32'(pc_q));
    apb(1'b0, ADDR_STK_FLAG, 32'h0);
    chk("flags kept", 32'h2, rd);
    apb(1'b0, ADDR_TOS_LOW, 32'h0);
    chk("tos empty", 32'h0, rd);
    apb(1'b0, ADDR_TOS_HIGH, 32'h0);
    chk("tos high empty", 32'h0, rd);
    apb(1'b1, ADDR_STK_FLAG, 32'h3);
    apb(1'b0, ADDR_STK_FLAG, 32'h0);
    chk("flags clear", 32'h0, rd);
    apb(1'b1, ADDR_STK_PTR, 32'(SP_FULL));
    op(OP_CALL, rnd[10:0], 8'h0);
    chk("stack reset ovf", 32'h1, 32'(srq));
    apb(1'b0, ADDR_STK_PTR, 32'h0);
    chk("sp ovf reset", 32'(SP_EMPTY), rd);
    apb(1'b0, ADDR_STK_FLAG, 32'h0);
    chk("ovf flag guarded", 32'h1, rd);
    // Power-on reset in mid-run is the only thing besides software that clears the flags
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    apb(1'b0, ADDR_STK_FLAG, 32'h0);
    chk("flags power-on", 32'h0, rd);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk("config power-on", 32'h0, rd);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    end_of_test();
  end
endmodule

// ===== hdl/pcrs_core.sv
/*
  Program counter, 16-level return stack and status flag protection.
  Assumes decoder and ALU run on pclk and the APB master keeps APB rules.
*/
`timescale 1ns/1ps
module pcrs_core
  import pcrs_pkg::*;
(
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // Core side
  input  wire pcrs_core_req_t core_req,
  input  wire pcrs_alu_t      alu,
  input  wire logic           soft_reset,
  input  wire logic           timeout_evt,
  input  wire logic           sleep_evt,
  input  wire logic           wdt_clear_evt,
  // Results
  output logic      [14:0]    pc_q,
  output logic      [7:0]     status_q,
  output logic                stack_reset_req_q,
  output logic                irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [14:0] stack_mem [STK_DEPTH];
  logic [4:0]  sp_q;
  logic [6:0]  latch_q;
  logic        stack_overflow_reset_enable_q;
  logic [1:0]  stk_flag_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic [14:0] pc_d;
  logic [4:0]  sp_d;
  logic        push;
  logic        pop;
  logic        ovf;
  logic        unf;
  logic        stk_reset;
  logic [14:0] pc_inc;
  logic [14:0] tos;
  logic        wr_en;
  logic        rd_en;

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pc_inc  = pc_q + 15'h0001;

  // Stack entry under the pointer; empty guarded stack reads zero
  function automatic logic [14:0] tos_view(input logic [4:0] sp, input logic en,
                                           input logic [14:0] e);
    return (sp == SP_EMPTY && en) ? 15'h0000 : e;
  endfunction

  assign tos = tos_view(sp_q, stack_overflow_reset_enable_q, stack_mem[sp_q[3:0]]);

  // ----------------------------------------------------------------
  // Next program counter and stack action
  // ----------------------------------------------------------------
  always_comb begin
    pc_d = pc_q;
    push = 1'b0;
    pop  = 1'b0;
    unique case (core_req.op)
      OP_NONE:             pc_d = pc_q;
      OP_STEP:             pc_d = pc_inc;
      OP_WRITE_PCL:        pc_d = {latch_q, core_req.wr_data};
      OP_CALL: begin
        pc_d = {latch_q[6:3], core_req.operand};
        push = 1'b1;
      end
      OP_REGISTER_CALL: begin
        pc_d = {latch_q, core_req.w};
        push = 1'b1;
      end
      OP_REGISTER_BRANCH:  pc_d = pc_inc + {7'h00, core_req.w};
      OP_IMMEDIATE_BRANCH: pc_d = pc_inc + {{6{core_req.operand[8]}}, core_req.operand[8:0]};
      OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT: begin
        pc_d = stack_mem[sp_q[3:0]];
        pop  = 1'b1;
      end
      OP_VECTOR: begin
        pc_d = VECTOR_ADDR;
        push = 1'b1;
      end
      default:             pc_d = pc_q;
    endcase
  end

  assign ovf       = push && (sp_q == SP_FULL);
  assign unf       = pop && (sp_q == SP_EMPTY);
  assign stk_reset = (ovf || unf) && stack_overflow_reset_enable_q;

  // Wrapping keeps the stack circular when the guard is off
  always_comb begin
    sp_d = sp_q;
    if (push) begin
      sp_d = ovf ? SP_WRAP : 5'(sp_q + 5'h01);
    end else if (pop) begin
      sp_d = unf ? SP_FULL : 5'(sp_q - 5'h01);
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= PC_RESET;
    end else if (soft_reset || stk_reset) begin
      pc_q <= PC_RESET;
    end else if (core_req.op != OP_NONE) begin
      pc_q <= pc_d;
    end else if (wr_en && paddr == ADDR_PC_LOW) begin
      pc_q <= {latch_q, pwdata[7:0]};
    end
  end

  // High latch: only software writes it; resets and a guarded stack overflow or underflow clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 7'h00;
    end else if (soft_reset || stk_reset) begin
      latch_q <= 7'h00;
    end else if (wr_en && paddr == ADDR_PC_LATCH) begin
      latch_q <= pwdata[6:0];
    end
  end

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= SP_EMPTY;
    end else if (soft_reset || stk_reset) begin
      sp_q <= SP_EMPTY;
    end else if (push || pop) begin
      sp_q <= sp_d;
    end else if (wr_en && paddr == ADDR_STK_PTR) begin
      sp_q <= pwdata[4:0];
    end
  end

  // Entries are not cleared by reset, only the pointer moves
  always_ff @(posedge pclk) begin
    if (push && !stk_reset) begin
      stack_mem[sp_d[3:0]] <= (core_req.op == OP_VECTOR) ? pc_q : pc_inc;
    end else if (wr_en && paddr == ADDR_TOS_LOW) begin
      stack_mem[sp_q[3:0]] <= {stack_mem[sp_q[3:0]][14:8], pwdata[7:0]};
    end else if (wr_en && paddr == ADDR_TOS_HIGH) begin
      stack_mem[sp_q[3:0]] <= {pwdata[6:0], stack_mem[sp_q[3:0]][7:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_reset_req_q <= 1'b0;
    end else begin
      stack_reset_req_q <= stk_reset;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_overflow_reset_enable_q <= 1'b0;
    end else if (wr_en && paddr == ADDR_CONFIG) begin
      stack_overflow_reset_enable_q <= pwdata[0];
    end
  end

  // Flags survive the stack reset so the cause can be read; set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stk_flag_q <= 2'h0;
    end else begin
      stk_flag_q <= (stk_flag_q & ~((wr_en && paddr == ADDR_STK_FLAG) ? pwdata[1:0] : 2'h0))
                    | {unf, ovf};
    end
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= {3'h0, STATUS_RST};
    end else begin
      if (alu.upd_flags) begin
        status_q[BIT_Z]  <= alu.z;
        status_q[BIT_DC] <= alu.subtract ? !alu.dc_raw : alu.dc_raw;
        status_q[BIT_C]  <= alu.subtract ? !alu.c_raw : alu.c_raw;
      end else if (alu.dest_status) begin
        status_q[2:0]    <= alu.wr_data[2:0];
      end else if (wr_en && paddr == ADDR_STATUS) begin
        status_q[2:0]    <= pwdata[2:0];
      end
      // Only reset-cause events move these two
      if (wdt_clear_evt) begin
        status_q[BIT_TO] <= 1'b1;
        status_q[BIT_PD] <= 1'b1;
      end else begin
        if (timeout_evt) status_q[BIT_TO] <= 1'b0;
        if (sleep_evt)   status_q[BIT_PD] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= ((rd_en && paddr == ADDR_IRQ_STAT) ? 2'h0 : irq_stat_q) | {unf, ovf};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= 2'h0;
    end else if (wr_en && paddr == ADDR_IRQ_MASK) begin
      irq_mask_q <= pwdata[1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // APB read data and error
  // ----------------------------------------------------------------
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      ADDR_PC_LOW:   prdata = {24'h0, pc_q[7:0]};
      ADDR_PC_LATCH: prdata = {25'h0, latch_q};
      ADDR_STATUS:   prdata = {27'h0, status_q[4:0]};
      ADDR_STK_PTR:  prdata = {27'h0, sp_q};
      ADDR_TOS_LOW:  prdata = {24'h0, tos[7:0]};
      ADDR_TOS_HIGH: prdata = {25'h0, tos[14:8]};
      ADDR_CONFIG:   prdata = {31'h0, stack_overflow_reset_enable_q};
      ADDR_STK_FLAG: prdata = {30'h0, stk_flag_q};
      ADDR_IRQ_STAT: prdata = {30'h0, irq_stat_q};
      ADDR_IRQ_MASK: prdata = {30'h0, irq_mask_q};
      default:       pslverr = psel && penable;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_pcl_write_load: assert property (
    core_req.op == OP_WRITE_PCL && !soft_reset |=> pc_q == {$past(latch_q), $past(core_req.wr_data)})
    else $error("low byte write did not load the latch");
  chk_call_target: assert property (
    core_req.op == OP_CALL && !soft_reset && !stk_reset
    |=> pc_q == {$past(latch_q[6:3]), $past(core_req.operand)})
    else $error("call target wrong");
  chk_reg_branch: assert property (
    core_req.op == OP_REGISTER_BRANCH && !soft_reset
    |=> pc_q == 15'($past(pc_q) + 15'h0001 + {7'h00, $past(core_req.w)}))
    else $error("register branch target wrong");
  chk_push_order: assert property (
    push && !stk_reset && !soft_reset && sp_q != SP_FULL
    |=> sp_q == 5'($past(sp_q) + 5'h01)
        && stack_mem[sp_q[3:0]] == ($past(core_req.op) == OP_VECTOR ? $past(pc_q) : $past(pc_inc)))
    else $error("push did not store after increment");
  chk_pop_order: assert property (
    pop && !stk_reset && !soft_reset
    |=> pc_q == $past(stack_mem[sp_q[3:0]])
        && sp_q == ($past(sp_q) == SP_EMPTY ? SP_FULL : 5'($past(sp_q) - 5'h01)))
    else $error("pop did not read before decrement");
  chk_reg_call: assert property (
    core_req.op == OP_REGISTER_CALL && !soft_reset && !stk_reset
    |=> pc_q == {$past(latch_q), $past(core_req.w)})
    else $error("register call target wrong");
  chk_imm_branch: assert property (
    core_req.op == OP_IMMEDIATE_BRANCH && !soft_reset
    |=> pc_q == 15'($past(pc_q) + 15'h0001 + {{6{$past(core_req.operand[8])}}, $past(core_req.operand[8:0])}))
    else $error("immediate branch target wrong");
  chk_ovf_flag: assert property (
    ovf |=> stk_flag_q[BIT_OVF] ##1 stk_flag_q[BIT_OVF] || $past(wr_en))
    else $error("overflow flag not set");
  chk_ovf_reset: assert property (
    (ovf || unf) && stack_overflow_reset_enable_q |=> stack_reset_req_q && pc_q == PC_RESET && sp_q == SP_EMPTY)
    else $error("guarded stack fault did not reset");
  chk_wrap_push: assert property (
    ovf && !stack_overflow_reset_enable_q && !soft_reset |=> sp_q == SP_WRAP && stack_mem[0] == $past(
      core_req.op == OP_VECTOR ? pc_q : pc_inc))
    else $error("circular push wrong");
  chk_to_pd_guard: assert property (
    !timeout_evt && !sleep_evt && !wdt_clear_evt |=> $stable(status_q[4:3]))
    else $error("timeout or power-down flag moved");
  chk_sub_carry: assert property (
    alu.upd_flags && alu.subtract |=> status_q[BIT_C] == !$past(alu.c_raw) && status_q[BIT_DC] == !$past(alu.dc_raw))
    else $error("borrow not inverted");
  chk_empty_tos: assert property (
    sp_q == SP_EMPTY && stack_overflow_reset_enable_q |-> tos == 15'h0000)
    else $error("empty guarded stack not zero");

endmodule

// ===== hdl/pcrs_pkg.sv
/*
  Constants, register map and carrier types for the program counter and
  return stack block. Assumes one core clock and an APB register port.
*/
package pcrs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PC_LOW   = 8'h00;
  localparam logic [7:0] ADDR_PC_LATCH = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_STK_PTR  = 8'h0C;
  localparam logic [7:0] ADDR_TOS_LOW  = 8'h10;
  localparam logic [7:0] ADDR_TOS_HIGH = 8'h14;
  localparam logic [7:0] ADDR_CONFIG   = 8'h18;
  localparam logic [7:0] ADDR_STK_FLAG = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          BIT_C       = 0;
  localparam int          BIT_DC      = 1;
  localparam int          BIT_Z       = 2;
  localparam int          BIT_PD      = 3;
  localparam int          BIT_TO      = 4;
  localparam int          BIT_OVF     = 0;
  localparam int          BIT_UNF     = 1;
  localparam int          PC_W        = 15;
  localparam int          STK_DEPTH   = 16;
  localparam logic [4:0]  SP_EMPTY    = 5'h1F;
  localparam logic [4:0]  SP_FULL     = 5'h0F;
  localparam logic [4:0]  SP_WRAP     = 5'h00;
  localparam logic [14:0] PC_RESET    = 15'h0000;
  localparam logic [14:0] VECTOR_ADDR = 15'h0004;
  localparam logic [4:0]  STATUS_RST  = 5'h18;

  // ----------------------------------------------------------------
  // Carriers from the decoder and the ALU
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_STEP, OP_WRITE_PCL, OP_CALL, OP_REGISTER_CALL,
    OP_REGISTER_BRANCH, OP_IMMEDIATE_BRANCH, OP_RETURN,
    OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT, OP_VECTOR
  } pcrs_op_t;

  typedef struct packed {
    pcrs_op_t    op;
    logic [10:0] operand;
    logic [7:0]  w;
    logic [7:0]  wr_data;
  } pcrs_core_req_t;

  typedef struct packed {
    logic       dest_status;
    logic       upd_flags;
    logic       subtract;
    logic       z;
    logic       dc_raw;
    logic       c_raw;
    logic [7:0] wr_data;
  } pcrs_alu_t;

endpackage
